// ### cpls_check_sva.sv
// Checker: port assertions of the CPU priority level block
`timescale 1ns/10ps
`default_nettype none
module cpls_check
    import cpls_pkg::*;
(
    input wire logic                    clk,             // clock
    input wire logic                    arst_n,          // reset
    input wire cpls_pkg::cpls_apb_req_t apb_req,         // request
    input wire logic [31:0]             prdata,          // read data
    input wire logic                    pready,          // ready
    input wire logic                    pslverr,         // error
    input wire logic [3:0]              cpu_level,       // level
    input wire logic                    user_int_blocked // blocked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic nest_ff;
    logic nxt_nest;
    logic take;
    logic wst;
    logic rd;
    assign take = apb_req.psel & apb_req.penable & !pready;
    assign wst = take & apb_req.pwrite & (apb_req.paddr == CPLS_ADDR_STATUS);
    assign rd = pready & !apb_req.pwrite;
    // Shadow of the lock bit, so writes can be judged without reading it
    always_comb
        nxt_nest = (take & apb_req.pwrite & (apb_req.paddr == CPLS_ADDR_INTCTL1))
            ? apb_req.pwdata[15] : nest_ff;
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) nest_ff <= 1'b0;
        else nest_ff <= nxt_nest;
    wr_field_a: assert property (
        wst && !nest_ff |=> cpu_level[2:0] == $past(apb_req.pwdata[7:5])) else $error("field lost");
    nest_lock_a: assert property (
        wst && nest_ff |=> $stable(cpu_level[2:0])) else $error("locked field changed");
    full_blk_a: assert property (
        &cpu_level[2:0] |-> user_int_blocked) else $error("level 7 not blocked");
    hi_blk_a: assert property (
        cpu_level[3] |-> user_int_blocked) else $error("high level not blocked");
    rd_status_a: assert property (
        rd && apb_req.paddr == CPLS_ADDR_STATUS |-> prdata[7:5] == cpu_level[2:0])
        else $error("status read wrong");
    rd_core_a: assert property (
        rd && apb_req.paddr == CPLS_ADDR_CORE |-> prdata[3] == cpu_level[3])
        else $error("core bit wrong");
    rd_level_a: assert property (
        rd && apb_req.paddr == CPLS_ADDR_LEVEL |-> prdata[4:0] == {user_int_blocked, cpu_level})
        else $error("level read wrong");
    rst_zero_a: assert property (
        !$past(arst_n) |-> cpu_level == 4'h0) else $error("level not zero");
    cover property (wst && nest_ff);
    cover property (user_int_blocked && !cpu_level[3]);
    cover property (cpu_level[3]);
endmodule : cpls_check
bind cpls_top cpls_check chk_u (.clk(clk), .arst_n(arst_n), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_level(cpu_level),
    .user_int_blocked(user_int_blocked));
`default_nettype wire

// ### cpls_level_calc.sv
// Combinational effective priority level and user interrupt block
`timescale 1ns/10ps
`default_nettype none
module cpls_level_calc
    import cpls_pkg::*;
(
    input  wire logic [2:0]       prio_field,    // Three-bit priority field
    input  wire logic             high_prio,     // High priority bit of core control
    output cpls_pkg::cpls_level_t level_out      // Effective level and block flag
);
    always_comb
    begin
        level_out.level        = {high_prio, prio_field};
        level_out.user_blocked = high_prio || (prio_field == CPLS_PRIO_MAX);
    end
endmodule : cpls_level_calc
`default_nettype wire

// ### cpls_pkg.sv
// Package: register map, field layout and types of the CPU priority level block
package cpls_pkg;

    // ****************************************************************
    // Register map (byte addresses of 32-bit words)
    // ****************************************************************
    localparam logic [11:0] CPLS_ADDR_STATUS  = 12'h000;
    localparam logic [11:0] CPLS_ADDR_CORE    = 12'h004;
    localparam logic [11:0] CPLS_ADDR_INTCTL1 = 12'h008;
    localparam logic [11:0] CPLS_ADDR_LEVEL   = 12'h00c;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int CPLS_STATUS_W     = 16;
    localparam int CPLS_PRIO_LSB     = 5;
    localparam int CPLS_PRIO_MSB     = 7;
    localparam int CPLS_PRIO_W       = 3;
    localparam int CPLS_LEVEL_W      = 4;
    localparam int CPLS_CORE_HI_BIT  = 3;
    localparam int CPLS_NEST_DIS_BIT = 15;
    localparam int CPLS_BLOCK_BIT    = 4;

    // ****************************************************************
    // Values
    // ****************************************************************
    localparam logic [2:0]  CPLS_PRIO_RESET = 3'h0;
    localparam logic [2:0]  CPLS_PRIO_MAX   = 3'h7;
    localparam logic [15:0] CPLS_REG_RESET  = 16'h0000;
    localparam logic [31:0] CPLS_RD_ZERO    = 32'h0000_0000;

    // Level pair presented to the interrupt logic
    typedef struct packed {
        logic       user_blocked;
        logic [3:0] level;
    } cpls_level_t;

    // APB request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cpls_apb_req_t;

endpackage : cpls_pkg

// ### cpls_top.sv
// Top: APB register slave holding the CPU priority level state
//
// What this block does
// - Priority field sits in status bits 7..5; value equals level 0 to 7.
// - Field value 111 blocks all user interrupts.
// - Effective level is core control bit 3 above the three-bit field.
// - High priority bit set gives effective level field plus eight.
// - High priority bit set blocks all user interrupts regardless of field.
// - Nesting disable (interrupt control bit 15) makes the field read-only.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cpls_top
    import cpls_pkg::*;
(
    input  wire logic                  clk,          // 50 MHz clock
    input  wire logic                  arst_n,       // Async reset, active low
    input  wire cpls_pkg::cpls_apb_req_t apb_req,    // APB request signals
    output logic [31:0]                prdata,       // APB read data
    output logic                       pready,       // APB ready
    output logic                       pslverr,      // APB error
    output logic [3:0]                 cpu_level,    // Effective CPU priority level
    output logic                       user_int_blocked // User interrupts blocked
);
    import cpls_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [2:0]  prio_ff,    nxt_prio;
    logic [15:0] core_ff,    nxt_core;
    logic [15:0] intctl_ff,  nxt_intctl;
    logic [31:0] prdata_ff,  nxt_prdata;
    logic        pready_ff,  nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic [3:0]  level_ff,   nxt_level;
    logic        blk_ff,     nxt_blk;
    cpls_level_t calc;

    logic access;
    logic wr;
    logic hit;
    logic [15:0] status_view;

    // Level computed from the values that will be registered, so the
    // outputs track the register contents with no extra cycle of lag
    cpls_level_calc u_calc (
        .prio_field (nxt_prio),
        .high_prio  (nxt_core[CPLS_CORE_HI_BIT]),
        .level_out  (calc)
    );

    // ****************************************************************
    // Bus decode and next state
    // ****************************************************************
    always_comb
    begin
        // One wait state: pready is registered and rises in the second access-phase cycle
        access      = apb_req.psel && apb_req.penable && !pready_ff;
        wr          = access && apb_req.pwrite;
        hit         = (apb_req.paddr == CPLS_ADDR_STATUS)  ||
                      (apb_req.paddr == CPLS_ADDR_CORE)    ||
                      (apb_req.paddr == CPLS_ADDR_INTCTL1) ||
                      (apb_req.paddr == CPLS_ADDR_LEVEL);
        status_view = CPLS_REG_RESET;
        status_view[CPLS_PRIO_MSB:CPLS_PRIO_LSB] = prio_ff;

        nxt_prio    = prio_ff;
        nxt_core    = core_ff;
        nxt_intctl  = intctl_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = access;
        nxt_pslverr = access && !hit;

        if (wr)
        begin
            unique case (apb_req.paddr)
                CPLS_ADDR_STATUS:
                begin
                    // Only the priority field is held here; write blocked
                    // while nesting is disabled
                    if (!intctl_ff[CPLS_NEST_DIS_BIT])
                        nxt_prio = apb_req.pwdata[CPLS_PRIO_MSB:CPLS_PRIO_LSB];
                end
                CPLS_ADDR_CORE:    nxt_core   = apb_req.pwdata[CPLS_STATUS_W-1:0];
                CPLS_ADDR_INTCTL1: nxt_intctl = apb_req.pwdata[CPLS_STATUS_W-1:0];
                default:           nxt_prio   = prio_ff;
            endcase
        end

        if (access && !apb_req.pwrite)
        begin
            nxt_prdata = CPLS_RD_ZERO;
            unique case (apb_req.paddr)
                CPLS_ADDR_STATUS:  nxt_prdata[CPLS_STATUS_W-1:0] = status_view;
                CPLS_ADDR_CORE:    nxt_prdata[CPLS_STATUS_W-1:0] = core_ff;
                CPLS_ADDR_INTCTL1: nxt_prdata[CPLS_STATUS_W-1:0] = intctl_ff;
                CPLS_ADDR_LEVEL:
                begin
                    nxt_prdata[CPLS_LEVEL_W-1:0] = level_ff;
                    nxt_prdata[CPLS_BLOCK_BIT]   = blk_ff;
                end
                default:           nxt_prdata = CPLS_RD_ZERO;
            endcase
        end

    end

    // Level group in its own process: the calculator reads the bus
    // process's next values, so sharing one process would form a false loop
    always_comb
    begin
        nxt_level = calc.level;
        nxt_blk   = calc.user_blocked;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prio_ff    <= CPLS_PRIO_RESET;
            core_ff    <= CPLS_REG_RESET;
            intctl_ff  <= CPLS_REG_RESET;
            prdata_ff  <= CPLS_RD_ZERO;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            level_ff   <= 4'h0;
            blk_ff     <= 1'b0;
        end
        else
        begin
            prio_ff    <= nxt_prio;
            core_ff    <= nxt_core;
            intctl_ff  <= nxt_intctl;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            level_ff   <= nxt_level;
            blk_ff     <= nxt_blk;
        end
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign cpu_level        = level_ff;
    assign user_int_blocked = blk_ff;

endmodule : cpls_top
`default_nettype wire

// ### test_cpu_priority_level_status.sv
// Testbench: random register traffic for the CPU priority level block
`timescale 1ns/10ps
`default_nettype none
module test_cpu_priority_level_status;
    import cpls_pkg::*;
    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    cpls_apb_req_t apb_req = '0;
    logic [31:0]   prdata;
    logic [31:0]   rdv;
    logic          pready;
    logic          pslverr;
    logic          errv;
    logic          user_int_blocked;
    logic          h;
    logic          n;
    logic [3:0]    cpu_level;
    logic [2:0]    fld;
    logic [2:0]    f;
    integer        seed = 50706;
    integer        error_cnt = 0;
    integer        checks = 0;
    integer        i;
    always #10 clk = ~clk;
    cpls_top dut_u (.clk(clk), .arst_n(arst_n), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_level(cpu_level),
        .user_int_blocked(user_int_blocked));
    function automatic logic [31:0] exp_lvl(input logic hi, input logic [2:0] fv);
        return {27'h0, hi | (fv == 3'h7), hi, fv};
    endfunction : exp_lvl
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge clk);
        if (k == 20)
        begin
            error_cnt++;
            conclude();
        end
        rdv = prdata;
        errv = pslverr;
        apb_req <= '0;
    endtask : xfer
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        xfer(1'b0, CPLS_ADDR_LEVEL, 32'h0);
        chk(rdv, 32'h0);
        chk({27'h0, user_int_blocked, cpu_level}, 32'h0);
        xfer(1'b0, 12'h010, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, errv}, 32'h1);
        $display("reset test done");
        fld = 3'h0;
        for (i = 0; i < 24; i++)
        begin
            n = (i % 4 == 3);
            h = 1'($random(seed));
            f = (i < 3) ? 3'h7 : 3'($random(seed));
            xfer(1'b1, CPLS_ADDR_INTCTL1, {16'h0, n, 15'($random(seed))});
            xfer(1'b1, CPLS_ADDR_CORE, {28'h0, h, 3'h0});
            xfer(1'b1, CPLS_ADDR_STATUS, ($random(seed) & 32'hff1f) | {f, 5'h0});
            if (!n) fld = f;
            xfer(1'b0, CPLS_ADDR_CORE, 32'h0);
            chk(rdv, {28'h0, h, 3'h0});
            xfer(1'b0, CPLS_ADDR_STATUS, 32'h0);
            chk(rdv, {24'h0, fld, 5'h0});
            chk({31'h0, errv}, 32'h0);
            xfer(1'b0, CPLS_ADDR_LEVEL, 32'h0);
            chk(rdv, exp_lvl(h, fld));
            chk({28'h0, cpu_level}, {28'h0, h, fld});
            chk({27'h0, user_int_blocked, cpu_level}, exp_lvl(h, fld));
        end
        $display("random test done");
        // Corner cases: ignored writes, then a reset in mid-run from a raised level
        xfer(1'b1, CPLS_ADDR_INTCTL1, 32'h0);
        xfer(1'b1, CPLS_ADDR_CORE, 32'h8);
        xfer(1'b1, CPLS_ADDR_STATUS, 32'ha0);
        xfer(1'b1, CPLS_ADDR_LEVEL, 32'h0);
        xfer(1'b0, CPLS_ADDR_LEVEL, 32'h0);
        chk(rdv, exp_lvl(1'b1, 3'h5));
        xfer(1'b1, 12'h010, 32'hffff_ffff);
        chk({31'h0, errv}, 32'h1);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        xfer(1'b0, CPLS_ADDR_STATUS, 32'h0);
        chk(rdv, 32'h0);
        chk({27'h0, user_int_blocked, cpu_level}, 32'h0);
        xfer(1'b0, CPLS_ADDR_CORE, 32'h0);
        chk(rdv, 32'h0);
        $display("mid reset test done");
        conclude();
    end
endmodule : test_cpu_priority_level_status
`default_nettype wire
